// *** shared/gfs_pkg.sv ***
// Constants, field layout and carrier types of the global fault and status registers
package gfs_pkg;

    // Register offsets on the device register port
    localparam logic [7:0] GFS_ADDR_EVENT_RECORD = 8'h05;
    localparam logic [7:0] GFS_ADDR_LIVE_STATUS = 8'h06;
    localparam logic [7:0] GFS_ADDR_GLOBAL_CONFIG = 8'h10;

    // Software control field inside the global configuration register
    localparam int GFS_SOFT_CTRL_LSB = 0;
    localparam int GFS_SOFT_CTRL_MSB = 1;
    localparam logic [1:0] GFS_SOFT_COLD_RESET = 2'h1;
    localparam logic [1:0] GFS_SOFT_POWEROFF = 2'h2;

    // Watchdog action select encodings
    localparam logic GFS_WDT_ACTION_POWER_RESET = 1'b1;
    localparam logic GFS_WDT_ACTION_POWEROFF = 1'b0;

    // Event record bit positions
    localparam int GFS_EVR_WATCHDOG_RESET = 7;
    localparam int GFS_EVR_WATCHDOG_POWEROFF = 6;
    localparam int GFS_EVR_SOFT_COLD_RESET = 5;
    localparam int GFS_EVR_SOFT_POWEROFF = 4;
    localparam int GFS_EVR_MANUAL_RESET = 3;
    localparam int GFS_EVR_SUPPLY_UNDERVOLT = 2;
    localparam int GFS_EVR_SUPPLY_OVERVOLT = 1;
    localparam int GFS_EVR_THERMAL_OVERLOAD = 0;

    // Live status bit positions
    localparam int GFS_STS_METAL_OPTION_ID = 7;
    localparam int GFS_STS_BIAS_READY = 6;
    localparam int GFS_STS_LDO0_DROPOUT = 5;
    localparam int GFS_STS_LDO1_DROPOUT = 4;
    localparam int GFS_STS_THERMAL_ALARM2 = 3;
    localparam int GFS_STS_THERMAL_ALARM1 = 2;
    localparam int GFS_STS_ENABLE_ACTIVE = 1;
    localparam int GFS_STS_IRQ_DRIVE = 0;

    // Register widths and reset values
    localparam int GFS_REG_W = 8;
    localparam logic [7:0] GFS_EVENT_RESET = 8'h00;
    localparam logic [7:0] GFS_STATUS_RESET = 8'h40;
    localparam logic [7:0] GFS_UNMAPPED_READ = 8'h00;
    localparam logic GFS_FLAG_RESET = 1'b0;
    localparam logic GFS_LEVEL_RESET = 1'b0;

    // Timing: enable pin debounce time and its cycle count at the core clock
    localparam int GFS_CLK_PERIOD_NS = 4;
    localparam int GFS_T_DEBOUNCE_NS = 100;
    localparam int GFS_DEBOUNCE_CYC =
        (GFS_T_DEBOUNCE_NS + GFS_CLK_PERIOD_NS - 1) / GFS_CLK_PERIOD_NS;
    localparam int GFS_DEBOUNCE_W = $clog2(GFS_DEBOUNCE_CYC + 1);
    localparam logic [GFS_DEBOUNCE_W-1:0] GFS_DEBOUNCE_LAST =
        GFS_DEBOUNCE_W'(GFS_DEBOUNCE_CYC - 1);
    localparam logic [GFS_DEBOUNCE_W-1:0] GFS_DEBOUNCE_ZERO = '0;

    // Register port request, one access per cycle
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } gfs_reg_req_s;

    // Fault and supervisor event sources
    typedef struct packed {
        logic wdt_expire;
        logic watchdog_action_select;
        logic manual_reset;
        logic supply_undervolt;
        logic supply_overvolt;
        logic thermal_overload;
    } gfs_event_in_s;

    // Live analog and supervisor levels
    typedef struct packed {
        logic bias_ready;
        logic ldo0_dropout;
        logic ldo1_dropout;
        logic thermal_alarm2;
        logic thermal_alarm1;
    } gfs_live_in_s;

endpackage

// *** logic/gfs_flag_cell.sv ***
// One sticky event flag with clear-on-read, where a new event beats the clear
`timescale 1ns/100ps
`default_nettype none
module gfs_flag_cell
    import gfs_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Event and clear
    input wire logic set,
    input wire logic clr,
    // Flag
    output logic q
);

    logic next_q;

    // Set has priority so an event in the clearing cycle is kept
    always_comb
    begin
        next_q = q;
        if (set)
        begin
            next_q = 1'b1;
        end
        else if (clr)
        begin
            next_q = 1'b0;
        end
    end

    // Flag register, frozen while the clock enable is low
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= GFS_FLAG_RESET;
        end
        else if (ce)
        begin
            q <= next_q;
        end
    end

endmodule
`default_nettype wire

// *** logic/gfs_global_regs.sv ***
// Global event record and live status registers with interrupt pin drive
//
// Functional notes
// - Watchdog expiry with power-reset action sets event bit 7.
// - Watchdog expiry with power-off action sets event bit 6.
// - Software writing cold-reset code 01 to control field sets event bit 5.
// - Software writing power-off code 10 to control field sets event bit 4.
// - A manual reset event sets event bit 3.
// - Supply undervoltage lockout assertion sets event bit 2.
// - Supply overvoltage lockout assertion sets event bit 1.
// - Thermal overload above 165 C sets event bit 0.
// - Event flags reset to zero, stay set until read; a read clears all but those set in its own cycle.
// - Status bit 6 shows bias ready; resets to one.
// - Status bit 7 is a fixed read-only metal option identifier.
// - Status bit 3 is high while above thermal alarm two.
// - Status bit 2 is high while above thermal alarm one.
// - Status bit 1 is debounced enable pin, one when pin is low.
// - Status bit 0 mirrors the unmasked interrupt gate drive.
// - Interrupt pin pulls low on unmasked flag rise, releases when all clear.
`timescale 1ns/100ps
`default_nettype none
module gfs_global_regs
    import gfs_pkg::*;
#(
    // Factory metal option identifier; value is arbitrary
    parameter logic METAL_OPTION_ID = 1'b1
)
(
    // Clock, reset and clock enable
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // Register port from the serial interface engine
    input wire gfs_pkg::gfs_reg_req_s REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Event sources
    input wire gfs_pkg::gfs_event_in_s EVENTS,
    // Live levels
    input wire gfs_pkg::gfs_live_in_s LIVE,
    input wire logic ENABLE_PIN_N,
    // Interrupt flag summary from the interrupt bank
    input wire logic INT_UNMASKED_RISE,
    input wire logic INT_ANY_PENDING,
    // Open-drain interrupt pin
    output logic IRQ_N_O,
    output logic IRQ_N_OE
);

    import gfs_pkg::*;

    // Register port decode
    logic rd_event;
    logic rd_status;
    logic wr_config;
    logic [1:0] soft_ctrl_wr;

    // Level detector history for edge detection
    logic manual_reset_q;
    logic undervolt_q;
    logic overvolt_q;
    logic thermal_q;
    logic next_manual_reset_q;
    logic next_undervolt_q;
    logic next_overvolt_q;
    logic next_thermal_q;

    // Event record
    logic [GFS_REG_W-1:0] event_set;
    logic [GFS_REG_W-1:0] event_record_flags;

    // Enable pin debounce
    logic enable_raw;
    logic enable_db;
    logic next_enable_db;
    logic [GFS_DEBOUNCE_W-1:0] db_cnt;
    logic [GFS_DEBOUNCE_W-1:0] next_db_cnt;

    // Interrupt drive and live status
    logic irq_drive;
    logic next_irq_drive;
    logic [GFS_REG_W-1:0] global_live_status;
    logic [GFS_REG_W-1:0] next_global_live_status;

    // Read answer
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic next_irq_o;
    logic next_irq_oe;

    // Address decode; software control writes to the config address only set event flags, not stored
    always_comb
    begin
        rd_event = REG_REQ.rd && (REG_REQ.addr == GFS_ADDR_EVENT_RECORD);
        rd_status = REG_REQ.rd && (REG_REQ.addr == GFS_ADDR_LIVE_STATUS);
        wr_config = REG_REQ.wr && (REG_REQ.addr == GFS_ADDR_GLOBAL_CONFIG);
        soft_ctrl_wr = REG_REQ.wdata[GFS_SOFT_CTRL_MSB:GFS_SOFT_CTRL_LSB];
    end

    // Detector history; lockouts are levels, so only the rising edge
    // counts as a new event, else a held fault would refill after each read
    always_comb
    begin
        next_manual_reset_q = EVENTS.manual_reset;
        next_undervolt_q = EVENTS.supply_undervolt;
        next_overvolt_q = EVENTS.supply_overvolt;
        next_thermal_q = EVENTS.thermal_overload;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            manual_reset_q <= GFS_LEVEL_RESET;
            undervolt_q <= GFS_LEVEL_RESET;
            overvolt_q <= GFS_LEVEL_RESET;
            thermal_q <= GFS_LEVEL_RESET;
        end
        else if (CE)
        begin
            manual_reset_q <= next_manual_reset_q;
            undervolt_q <= next_undervolt_q;
            overvolt_q <= next_overvolt_q;
            thermal_q <= next_thermal_q;
        end
    end

    // Event set terms, one per record bit
    always_comb
    begin
        event_set = GFS_EVENT_RESET;
        event_set[GFS_EVR_WATCHDOG_RESET] = EVENTS.wdt_expire &&
            (EVENTS.watchdog_action_select == GFS_WDT_ACTION_POWER_RESET);
        event_set[GFS_EVR_WATCHDOG_POWEROFF] = EVENTS.wdt_expire &&
            (EVENTS.watchdog_action_select == GFS_WDT_ACTION_POWEROFF);
        event_set[GFS_EVR_SOFT_COLD_RESET] = wr_config &&
            (soft_ctrl_wr == GFS_SOFT_COLD_RESET);
        event_set[GFS_EVR_SOFT_POWEROFF] = wr_config &&
            (soft_ctrl_wr == GFS_SOFT_POWEROFF);
        event_set[GFS_EVR_MANUAL_RESET] =
            EVENTS.manual_reset && !manual_reset_q;
        event_set[GFS_EVR_SUPPLY_UNDERVOLT] =
            EVENTS.supply_undervolt && !undervolt_q;
        event_set[GFS_EVR_SUPPLY_OVERVOLT] =
            EVENTS.supply_overvolt && !overvolt_q;
        event_set[GFS_EVR_THERMAL_OVERLOAD] =
            EVENTS.thermal_overload && !thermal_q;
    end

    // Sticky flags, all cleared by a read of the record; set beats clear
    for (genvar i = 0; i < GFS_REG_W; i++)
    begin : g_flag
        gfs_flag_cell u_flag
        (
            .clk(CLK),
            .rst(RST),
            .ce(CE),
            .set(event_set[i]),
            .clr(rd_event),
            .q(event_record_flags[i])
        );
    end

    // Enable pin debounce: the new level must hold for the full window
    always_comb
    begin
        enable_raw = !ENABLE_PIN_N;
        next_enable_db = enable_db;
        next_db_cnt = GFS_DEBOUNCE_ZERO;
        if (enable_raw != enable_db)
        begin
            if (db_cnt == GFS_DEBOUNCE_LAST)
            begin
                next_enable_db = enable_raw;
            end
            else
            begin
                next_db_cnt = db_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            enable_db <= GFS_LEVEL_RESET;
            db_cnt <= GFS_DEBOUNCE_ZERO;
        end
        else if (CE)
        begin
            enable_db <= next_enable_db;
            db_cnt <= next_db_cnt;
        end
    end

    // Interrupt gate drive: a new unmasked flag wins over the release
    always_comb
    begin
        next_irq_drive = irq_drive;
        if (INT_UNMASKED_RISE)
        begin
            next_irq_drive = 1'b1;
        end
        else if (!INT_ANY_PENDING)
        begin
            next_irq_drive = 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            irq_drive <= GFS_LEVEL_RESET;
        end
        else if (CE)
        begin
            irq_drive <= next_irq_drive;
        end
    end

    // Live status sampled every cycle; reads see one cycle of lag
    always_comb
    begin
        next_global_live_status = GFS_STATUS_RESET;
        next_global_live_status[GFS_STS_METAL_OPTION_ID] = METAL_OPTION_ID;
        next_global_live_status[GFS_STS_BIAS_READY] = LIVE.bias_ready;
        next_global_live_status[GFS_STS_LDO0_DROPOUT] = LIVE.ldo0_dropout;
        next_global_live_status[GFS_STS_LDO1_DROPOUT] = LIVE.ldo1_dropout;
        next_global_live_status[GFS_STS_THERMAL_ALARM2] = LIVE.thermal_alarm2;
        next_global_live_status[GFS_STS_THERMAL_ALARM1] = LIVE.thermal_alarm1;
        next_global_live_status[GFS_STS_ENABLE_ACTIVE] = enable_db;
        next_global_live_status[GFS_STS_IRQ_DRIVE] = irq_drive;
    end

    // Reset value carries bias ready high and the fixed identifier
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            global_live_status <= GFS_STATUS_RESET;
            global_live_status[GFS_STS_METAL_OPTION_ID] <= METAL_OPTION_ID;
        end
        else if (CE)
        begin
            global_live_status <= next_global_live_status;
        end
    end

    // Read answer; the record returns its flags as held before the clear
    always_comb
    begin
        next_rdata = REG_RDATA;
        next_rvalid = REG_REQ.rd;
        if (rd_event)
        begin
            next_rdata = event_record_flags;
        end
        else if (rd_status)
        begin
            next_rdata = global_live_status;
        end
        else if (REG_REQ.rd)
        begin
            next_rdata = GFS_UNMAPPED_READ;
        end
    end

    // Open-drain pin: only ever driven low, enable follows the gate drive
    always_comb
    begin
        next_irq_o = 1'b0;
        next_irq_oe = next_irq_drive;
    end

    // Output registers, so every output leaves from a flip-flop
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            REG_RDATA <= GFS_UNMAPPED_READ;
            REG_RVALID <= 1'b0;
            IRQ_N_O <= 1'b0;
            IRQ_N_OE <= 1'b0;
        end
        else if (CE)
        begin
            REG_RDATA <= next_rdata;
            REG_RVALID <= next_rvalid;
            IRQ_N_O <= next_irq_o;
            IRQ_N_OE <= next_irq_oe;
        end
    end

endmodule
`default_nettype wire

// *** verif/gfs_global_regs_asserts.sv ***
// Concurrent checks on the global fault and status register block
`timescale 1ns/100ps
`default_nettype none
module gfs_global_regs_asserts
    import gfs_pkg::*;
#(
    parameter logic METAL_OPTION_ID = 1'b1
)
(
    // Clock
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // Register port
    input wire gfs_pkg::gfs_reg_req_s REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    // Sources
    input wire gfs_pkg::gfs_event_in_s EVENTS,
    input wire gfs_pkg::gfs_live_in_s LIVE,
    input wire logic ENABLE_PIN_N,
    input wire logic INT_UNMASKED_RISE,
    input wire logic INT_ANY_PENDING,
    // Pin
    input wire logic IRQ_N_O,
    input wire logic IRQ_N_OE
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);

    // Reads taken at this edge, per register
    wire logic rd5 = CE && REG_REQ.rd && REG_REQ.addr == GFS_ADDR_EVENT_RECORD;
    wire logic rd6 = CE && REG_REQ.rd && REG_REQ.addr == GFS_ADDR_LIVE_STATUS;

    // Each read answered at the next edge, nothing else answered
    AST_RD_ANSWER:
        assert property (CE && REG_REQ.rd |=> REG_RVALID) else $error("read not answered");
    AST_RD_QUIET:
        assert property (CE && !REG_REQ.rd |=> !REG_RVALID) else $error("stray answer");
    // Status shows the id, and levels two edges back; the level check is skipped just after reset
    AST_ST_ID:
        assert property (rd6 |=> REG_RDATA[7] == METAL_OPTION_ID) else $error("id bit wrong");
    AST_ST_LIVE:
        assert property (rd6 && !$past(RST) && $past(CE) |=>
            {REG_RDATA[6:2], REG_RDATA[0]} == {$past(LIVE, 2), $past(IRQ_N_OE, 2)})
        else $error("live bits wrong");
    // Pin pulled on a rise, held while pending, released when none pending
    AST_IRQ_SET:
        assert property (CE && INT_UNMASKED_RISE |=> IRQ_N_OE) else $error("irq not set");
    AST_IRQ_HOLD:
        assert property (CE && INT_ANY_PENDING && IRQ_N_OE |=> IRQ_N_OE)
        else $error("irq dropped early");
    AST_IRQ_FREE:
        assert property (CE && !INT_UNMASKED_RISE && !INT_ANY_PENDING |=> !IRQ_N_OE)
        else $error("irq not released");
    // An event is in the record read two edges later
    AST_EV_WDT:
        assert property (CE && EVENTS.wdt_expire ##1 !rd5 ##1 rd5 |=>
            REG_RDATA[6 + $past(EVENTS.watchdog_action_select, 3)])
        else $error("watchdog flag missing");
    AST_EV_UV:
        assert property (CE && $rose(EVENTS.supply_undervolt) ##1 !rd5 ##1 rd5 |=>
            REG_RDATA[2]) else $error("undervoltage flag missing");
endmodule

bind gfs_global_regs gfs_global_regs_asserts #(.METAL_OPTION_ID(METAL_OPTION_ID))
    gfs_global_regs_asserts_i (.CLK, .RST, .CE, .REG_REQ, .REG_RDATA, .REG_RVALID,
    .EVENTS, .LIVE, .ENABLE_PIN_N, .INT_UNMASKED_RISE, .INT_ANY_PENDING, .IRQ_N_O,
    .IRQ_N_OE);
`default_nettype wire

// *** verif/gfs_global_regs_tb.sv ***
// Self-checking bench of the global fault and status register block
`timescale 1ns/100ps
`default_nettype none
module gfs_global_regs_tb;
    import gfs_pkg::*;
    // Stimulus and observed outputs
    logic CLK = 1'b0;
    logic RST = 1'b1;
    gfs_reg_req_s req = '0;
    gfs_event_in_s ev = '0;
    gfs_live_in_s lv = '0;
    logic en_n = 1'b1;
    logic ce = 1'b1;
    logic rise = 1'b0;
    logic pend = 1'b0;
    logic [7:0] rdata;
    logic rvalid, irq_o, irq_oe;
    int bad_count = 0;
    int total_checks = 0;

    // 250 MHz core clock
    always #2 CLK = ~CLK;

    // Clock enable is driven so that the freeze can be exercised
    gfs_global_regs gfs_global_regs_i (.CLK(CLK), .RST(RST), .CE(ce),
        .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid), .EVENTS(ev),
        .LIVE(lv), .ENABLE_PIN_N(en_n), .INT_UNMASKED_RISE(rise),
        .INT_ANY_PENDING(pend), .IRQ_N_O(irq_o), .IRQ_N_OE(irq_oe));

    // Compare and count
    task automatic chk(input string n, input logic [8:0] g, input logic [8:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Verdict and stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One read; the answer is looked at just after the next edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge CLK);
        req.rd <= 1'b0;
        #1;
        chk("read", {rvalid, rdata}, {1'b1, e});
    endtask

    // Status read; waits so fresh level writes have landed (id is one)
    task automatic rds(input logic e, input logic q);
        #1;
        rd(GFS_ADDR_LIVE_STATUS, {1'b1, lv, e, q});
    endtask

    // Interrupt pin one edge on
    task automatic pin(input logic e);
        @(posedge CLK);
        rise <= 1'b0;
        #1;
        chk("irq pin", {irq_o, irq_oe}, {8'h00, e});
    endtask

    task automatic t_reset();
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        req.rd <= 1'b1;
        req.addr <= GFS_ADDR_LIVE_STATUS;
        @(posedge CLK);
        req.rd <= 1'b0;
        #1;
        chk("status reset", {rvalid, rdata}, 9'h1C0);
        rds(1'b0, 1'b0);
        rd(GFS_ADDR_EVENT_RECORD, GFS_EVENT_RESET);
        rd(8'h33, GFS_UNMAPPED_READ);
        $display("done reset");
    endtask

    // Each source alone; a held level must not set again after the read
    task automatic t_events();
        for (int k = 7; k >= 0; k--)
        begin
            @(posedge CLK);
            ev.wdt_expire <= k >= 6;
            ev.watchdog_action_select <= k == 7;
            ev[3:0] <= 4'(k < 4 ? 1 << k : 0);
            req.wr <= k == 5 || k == 4;
            req.addr <= GFS_ADDR_GLOBAL_CONFIG;
            req.wdata <= {6'h00,
                k == 5 ? GFS_SOFT_COLD_RESET : GFS_SOFT_POWEROFF};
            @(posedge CLK);
            ev.wdt_expire <= 1'b0;
            req.wr <= 1'b0;
            rd(GFS_ADDR_EVENT_RECORD,
                8'(1 << k));
            rd(GFS_ADDR_EVENT_RECORD, 8'h00);
        end
        @(posedge CLK);
        ev <= '0;
        @(posedge CLK);
        req.rd <= 1'b1;
        req.addr <= GFS_ADDR_EVENT_RECORD;
        ev <= 6'h06;
        @(posedge CLK);
        req.rd <= 1'b0;
        #1;
        chk("coincide", {1'b0, rdata}, 9'h000);
        rd(GFS_ADDR_EVENT_RECORD, 8'h06);
        $display("done events");
    endtask

    task automatic t_live();
        @(posedge CLK);
        ev <= '0;
        lv <= 5'h1A;
        rds(1'b0, 1'b0);
        @(posedge CLK);
        lv <= 5'h05;
        rds(1'b0, 1'b0);
        $display("done live");
    endtask

    // A one-cycle bounce must restart the debounce count
    task automatic t_enable();
        @(posedge CLK);
        en_n <= 1'b0;
        repeat (18) @(posedge CLK);
        rds(1'b0, 1'b0);
        @(posedge CLK);
        en_n <= 1'b1;
        @(posedge CLK);
        en_n <= 1'b0;
        repeat (18) @(posedge CLK);
        rds(1'b0, 1'b0);
        repeat (8) @(posedge CLK);
        rds(1'b1, 1'b0);
        $display("done enable");
    endtask

    task automatic t_irq();
        @(posedge CLK);
        rise <= 1'b1;
        pend <= 1'b1;
        pin(1'b1);
        rds(1'b1, 1'b1);
        @(posedge CLK);
        pend <= 1'b0;
        pin(1'b0);
        rds(1'b1, 1'b0);
        @(posedge CLK);
        rise <= 1'b1;
        pin(1'b1);
        pin(1'b0);
        $display("done irq");
    endtask

    // Refused control code, then a low clock enable must ignore a read and a rise
    task automatic t_freeze();
        @(posedge CLK);
        req.wr <= 1'b1;
        req.addr <= GFS_ADDR_GLOBAL_CONFIG;
        req.wdata <= 8'h03;
        @(posedge CLK);
        req.wr <= 1'b0;
        rd(GFS_ADDR_EVENT_RECORD, 8'h00);
        @(posedge CLK);
        ce <= 1'b0;
        req.rd <= 1'b1;
        rise <= 1'b1;
        ev.supply_overvolt <= 1'b1;
        @(posedge CLK);
        req.rd <= 1'b0;
        rise <= 1'b0;
        #1;
        chk("frozen read", {rvalid, rdata}, 9'h000);
        chk("frozen pin", {irq_o, irq_oe}, 9'h000);
        @(posedge CLK);
        ce <= 1'b1;
        rd(GFS_ADDR_EVENT_RECORD, 8'h02);
        $display("done freeze");
    endtask

    // A mid-run reset drops a set flag and the pin even with interrupts pending
    task automatic t_rerun();
        @(posedge CLK);
        ev <= 6'h08;
        rise <= 1'b1;
        pend <= 1'b1;
        @(posedge CLK);
        rise <= 1'b0;
        RST <= 1'b1;
        ev <= '0;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        pend <= 1'b0;
        #1;
        chk("reset pin", {irq_o, irq_oe}, 9'h000);
        rd(GFS_ADDR_EVENT_RECORD, GFS_EVENT_RESET);
        $display("done rerun");
    endtask

    // Main sequence
    initial
    begin
        t_reset();
        t_events();
        t_live();
        t_enable();
        t_irq();
        t_freeze();
        t_rerun();
        end_sim();
    end

    // Cuts a hang short
    initial
    begin
        #100000;
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
